// *** shared/bbs_pkg.sv ***
`default_nettype none
package bbs_pkg;
  // Register byte offsets
  localparam logic [7:0] XLAT_OFS = 8'hA8;
  localparam logic [7:0] SETUP_OFS = 8'hAC;
  localparam logic [7:0] CAPHDR_OFS = 8'hB0;
  localparam logic [7:0] DEVCAP_OFS = 8'hB4;
  localparam logic [7:0] WBASE_OFS = 8'hE0;
  // Setup word fields
  localparam int SETUP_TYPE_BIT = 0;
  localparam int SETUP_ATYPE_LSB = 1;
  localparam int SETUP_PREF_BIT = 3;
  localparam int SETUP_SIZE_LSB = 6;
  localparam int SETUP_SIZE_MSB = 30;
  localparam int SETUP_EN_BIT = 31;
  localparam logic [31:0] SETUP_RST = 32'h0000_0000;
  localparam logic [31:0] SETUP_KEEP = 32'hFFFF_FFCE;
  localparam logic [1:0] ATYPE_32 = 2'h0;
  localparam logic [1:0] ATYPE_64 = 2'h1;
  localparam logic [31:0] WIN_LOW_MASK = 32'h0000_003F;
  // Capability header fields
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_NEXT_LSB = 8;
  localparam int CAP_VER_LSB = 16;
  localparam int CAP_PTYPE_LSB = 20;
  localparam int CAP_SLOT_BIT = 24;
  localparam int CAP_MSG_LSB = 25;
  localparam logic [7:0] CAP_ID_VAL = 8'h10;
  localparam logic [7:0] CAP_NEXT_VAL = 8'hD8;
  localparam logic [3:0] CAP_VER_VAL = 4'h1;
  localparam logic [3:0] PTYPE_FWD = 4'h7;
  localparam logic [3:0] PTYPE_REV = 4'h8;
  localparam logic [4:0] CAP_MSG_VAL = 5'h00;
  // Device capability fields
  localparam int DC_MPS_LSB = 0;
  localparam int DC_PHANTOM_LSB = 3;
  localparam int DC_TAG_BIT = 5;
  localparam int DC_L0S_LSB = 6;
  localparam int DC_L1_LSB = 9;
  localparam logic [2:0] DC_MPS_RST = 3'h1;
  localparam logic [1:0] DC_PHANTOM_VAL = 2'h0;
  localparam logic DC_TAG_VAL = 1'b1;
  localparam logic [2:0] L0S_LT_64NS = 3'h0;
  localparam logic [2:0] L0S_512NS_1US = 3'h4;
  localparam logic [2:0] DC_L1_RST = 3'h0;
  localparam logic [31:0] XLAT_RST = 32'h0000_0000;
  localparam logic [31:0] WBASE_RST = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } bbs_state_t;
endpackage
`default_nettype wire

// *** rtl/bbs_regs.sv ***
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Type-selector bit of the setup word always reads zero; writes never change it.
// - Address-type field: 00 means 32-bit, 01 means 64-bit; separate prefetchable flag.
// - With setup bit 31 set, each set size bit 30..6 makes the matching base bit writable, clear ones read-only.
// - Setup bit 31 enables the base register; clear means window decodes nothing.
// - Capability header low byte reads 10h, version nibble 19..16 reads 1h.
// - Header bits 15..8 read D8h, pointing to the product-data capability.
// - Port type reads 0111 as forward bridge, 1000 as reverse bridge.
// - Slot-implemented bit 24 reads 0 forward, 1 reverse.
// - Phantom-function field bits 4..3 reads 00.
// - Device capability bit 5 reads 1: extended 8-bit tag supported.
// - L0s latency bits 8..6 use doubling range codes, 000 below 64 ns.
// - Translated base bits 31..6 supply the window address, size bits pick used bits.
module bbs_regs #(
  parameter logic [2:0] L0S_CODE = bbs_pkg::L0S_LT_64NS,
  parameter logic [2:0] MPS_CODE = bbs_pkg::DC_MPS_RST
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic strap_load,
  input wire logic strap_reverse,
  input wire logic [31:0] strap_writable,
  input wire logic [31:0] local_addr,
  output logic win_hit,
  output logic [31:0] win_xlat_addr,
  output logic reverse_mode
);
  import bbs_pkg::*;

  bbs_state_t state;
  bbs_state_t next_state;
  logic [31:0] setup;
  logic [31:0] xlat;
  logic [31:0] wbase;
  logic rev;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] bmask;
    bmask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~bmask) | (nw & bmask);
  endfunction

  wire logic req = read | write;
  wire logic in_ack = (state == ST_ACK);
  wire logic hit_xlat = (address == XLAT_OFS);
  wire logic hit_setup = (address == SETUP_OFS);
  wire logic hit_cap = (address == CAPHDR_OFS);
  wire logic hit_dev = (address == DEVCAP_OFS);
  wire logic hit_wbase = (address == WBASE_OFS);
  wire logic wr_go = ce & in_ack & write;

  wire logic win_en = setup[SETUP_EN_BIT];
  // Window mask: base bit 31 plus every enabled size bit
  wire logic [31:0] size_mask = {1'b1, setup[SETUP_SIZE_MSB:SETUP_SIZE_LSB], 6'h00};
  wire logic [31:0] wbase_wmask = win_en ? size_mask : 32'h0000_0000;
  wire logic [31:0] wbase_rd = win_en ? {wbase[31:6] & size_mask[31:6], 2'b00, setup[3:1], 1'b0} :
                               32'h0000_0000;
  wire logic [31:0] xlat_rd = {xlat[31:6], 6'h00};

  wire logic [31:0] setup_rd = setup & SETUP_KEEP;
  wire logic [3:0] ptype = rev ? PTYPE_REV : PTYPE_FWD;
  wire logic [31:0] cap_rd = {2'b00, CAP_MSG_VAL, rev, ptype, CAP_VER_VAL, CAP_NEXT_VAL,
                              CAP_ID_VAL};
  wire logic [31:0] dev_rd = {20'h00000, DC_L1_RST, L0S_CODE, DC_TAG_VAL,
                              DC_PHANTOM_VAL, MPS_CODE};

  wire logic [31:0] rd_mux = hit_xlat ? xlat_rd :
                             hit_setup ? setup_rd :
                             hit_cap ? cap_rd :
                             hit_dev ? dev_rd :
                             hit_wbase ? wbase_rd : UNMAPPED_RD;

  wire logic [31:0] next_xlat = be_merge(xlat, writedata, byteenable, ~WIN_LOW_MASK);
  wire logic [31:0] next_wbase = be_merge(wbase, writedata, byteenable, wbase_wmask);
  // Strap word drops the type selector and reserved bits
  wire logic [31:0] next_setup = strap_writable & SETUP_KEEP;
  wire logic hit_now = win_en & (((local_addr ^ wbase) & size_mask) == 32'h0000_0000);
  wire logic [31:0] xlat_now = (local_addr & ~size_mask) | (xlat & size_mask);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else if (ce) begin
      state <= next_state;
      waitrequest <= ~(state == ST_IDLE && req);
      readdata <= rd_mux;
    end
  end

  // Strap path is the only loader of the setup word and the port mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      setup <= SETUP_RST;
      rev <= 1'b0;
    end else if (ce && strap_load) begin
      setup <= next_setup;
      rev <= strap_reverse;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      xlat <= XLAT_RST;
      wbase <= WBASE_RST;
    end else if (wr_go) begin
      if (hit_xlat) begin
        xlat <= next_xlat;
      end
      if (hit_wbase) begin
        wbase <= next_wbase;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      win_hit <= 1'b0;
      win_xlat_addr <= 32'h0000_0000;
      reverse_mode <= 1'b0;
    end else if (ce) begin
      win_hit <= hit_now;
      win_xlat_addr <= xlat_now;
      reverse_mode <= rev;
    end
  end

  // Checks
  type_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (in_ack && read && hit_setup && ce) |=> (readdata[SETUP_TYPE_BIT] == 1'b0))
    else $error("setup type bit read nonzero");

  setup_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !strap_load |=> $stable(setup))
    else $error("setup changed without strap load");

  base_ro_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr_go && hit_wbase) |=> ((wbase & ~$past(wbase_wmask)) == ($past(wbase) & ~$past(wbase_wmask))))
    else $error("read-only base bit was written");

  win_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && !win_en) |=> !win_hit)
    else $error("disabled window decoded an address");

  cap_hdr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && in_ack && read && hit_cap) |=>
    (readdata[7:0] == 8'h10 && readdata[19:16] == 4'h1 && readdata[15:8] == 8'hD8))
    else $error("capability header constants wrong");

  port_type_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && in_ack && read && hit_cap) |=>
    (readdata[23:20] == ($past(rev) ? 4'h8 : 4'h7) && readdata[24] == $past(rev)))
    else $error("port type or slot bit does not follow strap");

  dev_cap_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && in_ack && read && hit_dev) |=> (readdata[4:3] == 2'b00 && readdata[5] == 1'b1))
    else $error("phantom or tag field wrong");

  one_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && !waitrequest) |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  ack_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && state == ST_IDLE && req) ##1 ce |-> !waitrequest)
    else $error("request not answered in one cycle");

  cap_id_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_cap) |=>
    (readdata[7:0] == 8'h10))
    else $error("capability id wrong");

  cap_ver_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_cap) |=>
    (readdata[19:16] == 4'h1))
    else $error("capability version wrong");

  next_ptr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_cap) |=>
    (readdata[15:8] == 8'hD8))
    else $error("next capability pointer wrong");

  fwd_type_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_cap && !rev) |=>
    (readdata[23:20] == 4'h7))
    else $error("forward port type wrong");

  rev_type_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_cap && rev) |=>
    (readdata[23:20] == 4'h8))
    else $error("reverse port type wrong");

  slot_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_cap) |=>
    (readdata[CAP_SLOT_BIT] == $past(rev)))
    else $error("slot implemented bit wrong");

  phantom_field_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_dev) |=>
    (readdata[4:3] == 2'b00))
    else $error("phantom function field wrong");

  ext_tag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_dev) |=>
    (readdata[5] == 1'b1))
    else $error("extended tag bit wrong");

  l0s_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_dev) |=>
    (readdata[8:6] == L0S_CODE))
    else $error("latency code wrong");

  dev_upper_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_dev) |=>
    (readdata[31:9] == 23'h000000))
    else $error("device capability upper bits wrong");

  setup_type_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_setup) |=>
    (readdata[0] == 1'b0))
    else $error("setup type bit nonzero");

  setup_rsvd_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_setup) |=>
    (readdata[5:4] == 2'b00))
    else $error("setup reserved bits nonzero");

  setup_attr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_setup) |=>
    (readdata[3:1] == $past(setup[3:1])))
    else $error("address type or prefetch bit wrong");

  setup_size_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_setup) |=>
    (readdata[31:6] == $past(setup[31:6])))
    else $error("size or enable bits wrong");

  type_reg_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (setup[SETUP_TYPE_BIT] == 1'b0))
    else $error("stored type bit nonzero");

  strap_copy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && strap_load) |=>
    (setup == ($past(strap_writable) & 32'hFFFF_FFCE)))
    else $error("strap word not loaded");

  strap_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && strap_load) |=>
    (rev == $past(strap_reverse)))
    else $error("strap mode not loaded");

  mode_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce |=>
    (reverse_mode == $past(rev)))
    else $error("mode output does not follow strap");

  ce_freeze_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ce |=>
    ($stable(setup) && $stable(rev) && $stable(xlat) && $stable(wbase) && $stable(state)))
    else $error("state moved while clock enable low");

  out_freeze_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ce |=>
    ($stable(readdata) && $stable(waitrequest) && $stable(win_hit) && $stable(win_xlat_addr)))
    else $error("output moved while clock enable low");

  xlat_low_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_xlat) |=>
    (readdata[5:0] == 6'h00))
    else $error("translated base low bits nonzero");

  xlat_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(wr_go && hit_xlat) |=>
    $stable(xlat))
    else $error("translated base changed without write");

  base_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(wr_go && hit_wbase) |=>
    $stable(wbase))
    else $error("window base changed without write");

  base_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_wbase && !win_en) |=>
    (readdata == 32'h0000_0000))
    else $error("disabled window base reads nonzero");

  base_mask_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && hit_wbase) |=>
    ((readdata[30:6] & ~$past(setup[30:6])) == 25'h0000000))
    else $error("read-only base bit reads nonzero");

  xlat_pass_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce |=>
    ((win_xlat_addr & ~$past(size_mask)) == ($past(local_addr) & ~$past(size_mask))))
    else $error("untranslated address bits wrong");

  xlat_sub_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce |=>
    ((win_xlat_addr & $past(size_mask)) == ($past(xlat) & $past(size_mask))))
    else $error("translated address bits wrong");

  hit_msb_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && (local_addr[31] != wbase[31])) |=>
    !win_hit)
    else $error("window hit with top bit mismatch");

  wait_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && state == ST_IDLE && !req) |=>
    waitrequest)
    else $error("waitrequest low without request");

  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && !(hit_xlat || hit_setup || hit_cap || hit_dev || hit_wbase)) |=>
    (readdata == 32'h0000_0000))
    else $error("unmapped address reads nonzero");

endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bbs_pkg::*;
  logic ref_clk, rstn, ce, read, write, waitrequest, strap_load, strap_reverse, win_hit, reverse_mode, r;
  logic [7:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, strap_writable, local_addr, win_xlat_addr, q, sw, d, b;
  int errors, checks;

  bbs_regs uut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .strap_load(strap_load), .strap_reverse(strap_reverse), .strap_writable(strap_writable),
    .local_addr(local_addr), .win_hit(win_hit), .win_xlat_addr(win_xlat_addr), .reverse_mode(reverse_mode));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] hdr_exp(input logic rev);
    return {7'h00, rev, rev ? 4'h8 : 4'h7, 4'h1, 8'hD8, 8'h10};
  endfunction

  function automatic logic [31:0] base_exp(input logic [31:0] s, input logic [31:0] v);
    return s[31] ? ((v & {1'b1, s[30:6], 6'h00}) | (s & 32'h0000_000E)) : 32'h0000_0000;
  endfunction

  function automatic logic [31:0] xl_exp(input logic [31:0] s, input logic [31:0] x, input logic [31:0] a);
    logic [31:0] m;
    m = {1'b1, s[30:6], 6'h00};
    return (a & ~m) | (x & m);
  endfunction

  task automatic complete_run;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] rd);
    @(posedge ref_clk);
    address <= a;
    writedata <= v;
    read <= ~w;
    write <= w;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic strap(input logic [31:0] v, input logic rev);
    @(posedge ref_clk);
    strap_load <= 1'b1;
    strap_writable <= v;
    strap_reverse <= rev;
    @(posedge ref_clk);
    strap_load <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic decode(input logic [31:0] a, input logic exp, input logic [31:0] xexp);
    @(posedge ref_clk);
    local_addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    check("win_hit", {31'h0, win_hit}, {31'h0, exp});
    check("win_xlat_addr", win_xlat_addr, xexp);
  endtask

  initial begin
    rstn = 1'b0; ce = 1'b1; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
    byteenable = 4'hF; strap_load = 1'b0; strap_reverse = 1'b0; strap_writable = 32'h0; local_addr = 32'h0;
    errors = 0;
    checks = 0;
    void'($urandom(32'h35E2));
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, SETUP_OFS, 32'h0, q);
    check("setup_reset", q, 32'h0000_0000);
    bus(1'b0, CAPHDR_OFS, 32'h0, q);
    check("cap_header_reset", q, hdr_exp(1'b0));
    bus(1'b0, 8'h40, 32'h0, q);
    check("unmapped", q, 32'h0000_0000);
    decode(32'h0000_0000, 1'b0, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      sw = $urandom();
      if (i == 0) sw = 32'hFFFF_FFFF;
      if (i == 1) sw[31] = 1'b0;
      if (i > 1) sw[11:6] = 6'h00;
      sw[2:1] = i[1] ? ATYPE_64 : ATYPE_32;
      r = i[0];
      strap(sw, r);
      @(negedge ref_clk);
      check("reverse_mode", {31'h0, reverse_mode}, {31'h0, r});
      bus(1'b1, SETUP_OFS, ~sw, q);
      bus(1'b0, SETUP_OFS, 32'h0, q);
      check("setup", q, sw & 32'hFFFF_FFCE);
      bus(1'b1, CAPHDR_OFS, $urandom(), q);
      bus(1'b0, CAPHDR_OFS, 32'h0, q);
      check("cap_header", q, hdr_exp(r));
      bus(1'b1, DEVCAP_OFS, $urandom(), q);
      bus(1'b0, DEVCAP_OFS, 32'h0, q);
      check("dev_cap", q, 32'h0000_0021);
      d = $urandom();
      bus(1'b1, WBASE_OFS, d, q);
      bus(1'b0, WBASE_OFS, 32'h0, b);
      check("win_base", b, base_exp(sw & 32'hFFFF_FFCE, d));
      d = $urandom();
      bus(1'b1, XLAT_OFS, d, q);
      bus(1'b0, XLAT_OFS, 32'h0, q);
      check("xlat_base", q, d & 32'hFFFF_FFC0);
      decode(b, sw[31], xl_exp(sw, d & 32'hFFFF_FFC0, b));
      decode(b ^ 32'h8000_0000, 1'b0, xl_exp(sw, d & 32'hFFFF_FFC0, b ^ 32'h8000_0000));
    end
    @(posedge ref_clk);
    ce <= 1'b0;
    strap(32'h0000_0000, ~r);
    ce <= 1'b1;
    @(negedge ref_clk);
    check("ce_mode", {31'h0, reverse_mode}, {31'h0, r});
    bus(1'b0, SETUP_OFS, 32'h0, q);
    check("ce_setup", q, sw & 32'hFFFF_FFCE);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
